// ---- inc/eio_defs.svh ----
// register offsets, reset values and field positions of the expansion i/o ports
`ifndef EIO_DEFS_SVH
`define EIO_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EIO_OFS_DUAL_LATCH 6'h00
`define EIO_OFS_DUAL_DIR 6'h04
`define EIO_OFS_DUAL_FSEL 6'h08
`define EIO_OFS_LOW_LATCH 6'h0c
`define EIO_OFS_MEM_MAP 6'h10
`define EIO_OFS_UP_LATCH 6'h14
`define EIO_OFS_UP_DIR 6'h18
`define EIO_OFS_RMW_CMD 6'h1c
`define EIO_OFS_RMW_RES 6'h20
`define EIO_OFS_STATUS 6'h24

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EIO_RST_DIR 8'hff
`define EIO_RST_FSEL 8'h00
`define EIO_RST_LATCH 8'h00
`define EIO_RST_MAP 3'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EIO_MAP_DIR_BIT 0
`define EIO_IRQ_PIN_BIT 3
`define EIO_CMD_OP_LSB 8
`define EIO_CMD_PORT_LSB 12
`define EIO_PORT_DUAL 2'h0
`define EIO_PORT_LOW 2'h1
`define EIO_PORT_UP 2'h2

// control outputs on the dual port: serial out, timer, compares
`define EIO_CTRL_OUT_MASK 8'hd1

`endif

// ---- inc/eio_pkg.sv ----
// types shared by the expansion i/o port logic
package eio_pkg;

    // immediate operations on a port
    typedef enum logic [3:0] {
        EIO_OP_ADD = 4'h0,
        EIO_OP_SUB = 4'h1,
        EIO_OP_AND = 4'h2,
        EIO_OP_OR = 4'h3,
        EIO_OP_XOR = 4'h4,
        EIO_OP_GT = 4'h8,
        EIO_OP_LT = 4'h9,
        EIO_OP_EQ = 4'ha,
        EIO_OP_NE = 4'hb,
        EIO_OP_ON = 4'hc,
        EIO_OP_OFF = 4'hd
    } eio_op_t;

    // number of upper-port pins carrying high address bits
    typedef enum logic [1:0] {
        EIO_SZ_256 = 2'h0,
        EIO_SZ_4K = 2'h1,
        EIO_SZ_16K = 2'h2,
        EIO_SZ_FULL = 2'h3
    } eio_size_t;

endpackage

// ---- src/eio_ports.sv ----
// dual-function, address/data and upper address ports with rmw logic
`timescale 1ns/1ps
`include "eio_defs.svh"

module eio_ports #(
    parameter bit REDUCED = 1'b0,
    parameter int ADDR_W = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hw_stop,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] ctrl_out,
    output logic [7:0] ctrl_in,
    input wire logic [15:0] bus_addr,
    input wire logic bus_ale,
    input wire logic bus_we,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [7:0] dual_pin_i,
    output logic [7:0] dual_pin_o,
    output logic [7:0] dual_pin_oe,
    input wire logic [7:0] low_pin_i,
    output logic [7:0] low_pin_o,
    output logic [7:0] low_pin_oe,
    input wire logic [7:0] up_pin_i,
    output logic [7:0] up_pin_o,
    output logic [7:0] up_pin_oe,
    input wire logic size_select_pin_a,
    input wire logic size_select_pin_b,
    output logic ext_irq2_request_flag
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 6) begin : g_addr_w_check
        $error("eio_ports: ADDR_W must be at least 6");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] dual_s1_q, dual_s2_q;
    logic [7:0] low_s1_q, low_s2_q;
    logic [7:0] up_s1_q, up_s2_q;
    logic [1:0] size_s1_q, size_s2_q;
    logic irq_pin_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dual_s1_q <= 8'h00;
            dual_s2_q <= 8'h00;
            low_s1_q <= 8'h00;
            low_s2_q <= 8'h00;
            up_s1_q <= 8'h00;
            up_s2_q <= 8'h00;
            size_s1_q <= 2'h0;
            size_s2_q <= 2'h0;
            irq_pin_q <= 1'b1;
        end else begin
            dual_s1_q <= dual_pin_i;
            dual_s2_q <= dual_s1_q;
            low_s1_q <= low_pin_i;
            low_s2_q <= low_s1_q;
            up_s1_q <= up_pin_i;
            up_s2_q <= up_s1_q;
            size_s1_q <= {size_select_pin_b, size_select_pin_a};
            size_s2_q <= size_s1_q;
            irq_pin_q <= dual_s2_q[`EIO_IRQ_PIN_BIT];
        end
    end

    // ------------------------------------------------------------
    // register strobes
    // ------------------------------------------------------------
    logic [7:0] wbyte;
    logic wr_dual_latch, wr_dual_dir, wr_dual_fsel, wr_low_latch;
    logic wr_map, wr_up_latch, wr_up_dir, wr_cmd, wr_status;

    assign wbyte = reg_wdata[7:0];
    assign wr_dual_latch = reg_wr && reg_addr == `EIO_OFS_DUAL_LATCH;
    assign wr_dual_dir = reg_wr && reg_addr == `EIO_OFS_DUAL_DIR;
    assign wr_dual_fsel = reg_wr && reg_addr == `EIO_OFS_DUAL_FSEL;
    assign wr_low_latch = reg_wr && reg_addr == `EIO_OFS_LOW_LATCH;
    assign wr_map = reg_wr && reg_addr == `EIO_OFS_MEM_MAP;
    assign wr_up_latch = reg_wr && reg_addr == `EIO_OFS_UP_LATCH;
    assign wr_up_dir = reg_wr && reg_addr == `EIO_OFS_UP_DIR;
    assign wr_cmd = reg_wr && reg_addr == `EIO_OFS_RMW_CMD;
    assign wr_status = reg_wr && reg_addr == `EIO_OFS_STATUS;

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    logic [7:0] dual_dir_q, dual_fsel_q, up_dir_q;
    logic [2:0] map_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dual_dir_q <= `EIO_RST_DIR;
            dual_fsel_q <= `EIO_RST_FSEL;
            up_dir_q <= `EIO_RST_DIR;
        end else if (hw_stop) begin
            dual_dir_q <= `EIO_RST_DIR;
            dual_fsel_q <= `EIO_RST_FSEL;
            up_dir_q <= `EIO_RST_DIR;
        end else begin
            if (wr_dual_dir) begin
                dual_dir_q <= wbyte;
            end
            if (wr_dual_fsel) begin
                dual_fsel_q <= wbyte;
            end
            if (wr_up_dir) begin
                up_dir_q <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            map_q <= `EIO_RST_MAP;
        end else if (wr_map) begin
            map_q <= reg_wdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // expansion size decode
    // ------------------------------------------------------------
    eio_pkg::eio_size_t size;
    logic low_exp, size_bad;
    logic [7:0] addr_mask;

    always_comb begin
        size_bad = 1'b0;
        if (REDUCED) begin
            unique case (size_s2_q)
                2'h0: size = eio_pkg::EIO_SZ_4K;
                2'h1: size = eio_pkg::EIO_SZ_16K;
                2'h3: size = eio_pkg::EIO_SZ_FULL;
                default: begin
                    size = eio_pkg::EIO_SZ_256;
                    size_bad = 1'b1;
                end
            endcase
        end else begin
            size = eio_pkg::eio_size_t'(map_q[2:1]);
        end
        unique case (size)
            eio_pkg::EIO_SZ_4K: addr_mask = 8'h0f;
            eio_pkg::EIO_SZ_16K: addr_mask = 8'h3f;
            eio_pkg::EIO_SZ_FULL: addr_mask = 8'hff;
            default: addr_mask = 8'h00;
        endcase
    end

    assign low_exp = REDUCED || map_q[2:1] != 2'h0;

    // ------------------------------------------------------------
    // port read values
    // ------------------------------------------------------------
    logic [7:0] dual_latch_q, low_latch_q, up_latch_q;
    logic [7:0] dual_rd, low_rd, up_rd;
    logic low_out;

    assign low_out = map_q[`EIO_MAP_DIR_BIT];

    localparam logic [7:0] CTRL_MASK = `EIO_CTRL_OUT_MASK;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            localparam bit CTRL_OUT = CTRL_MASK[gi];
            always_comb begin
                if (dual_fsel_q[gi]) begin
                    if (CTRL_OUT && !dual_dir_q[gi]) begin
                        dual_rd[gi] = ctrl_out[gi];
                    end else begin
                        dual_rd[gi] = dual_s2_q[gi];
                    end
                end else if (dual_dir_q[gi]) begin
                    dual_rd[gi] = dual_s2_q[gi];
                end else begin
                    dual_rd[gi] = dual_latch_q[gi];
                end
                if (CTRL_OUT && dual_fsel_q[gi]) begin
                    dual_pin_o[gi] = ctrl_out[gi];
                    dual_pin_oe[gi] = 1'b1;
                end else begin
                    dual_pin_o[gi] = dual_latch_q[gi];
                    dual_pin_oe[gi] = !dual_fsel_q[gi] && !dual_dir_q[gi];
                end
                if (addr_mask[gi]) begin
                    up_pin_o[gi] = bus_addr[8+gi];
                    up_pin_oe[gi] = 1'b1;
                    up_rd[gi] = up_s2_q[gi];
                end else begin
                    up_pin_o[gi] = up_latch_q[gi];
                    up_pin_oe[gi] = !up_dir_q[gi];
                    up_rd[gi] = up_dir_q[gi] ? up_s2_q[gi]
                                             : up_latch_q[gi];
                end
            end
        end
    endgenerate

    assign ctrl_in = dual_s2_q & dual_fsel_q & ~`EIO_CTRL_OUT_MASK;

    // ------------------------------------------------------------
    // low address/data port
    // ------------------------------------------------------------
    always_comb begin
        if (low_exp) begin
            low_pin_o = bus_ale ? bus_addr[7:0] : bus_wdata;
            low_pin_oe = (bus_ale || bus_we) ? 8'hff : 8'h00;
            low_rd = low_s2_q;
        end else begin
            low_pin_o = low_latch_q;
            low_pin_oe = low_out ? 8'hff : 8'h00;
            low_rd = low_out ? low_latch_q : low_s2_q;
        end
    end

    assign bus_rdata = low_s2_q;

    // ------------------------------------------------------------
    // immediate operation unit
    // ------------------------------------------------------------
    eio_pkg::eio_op_t op;
    logic [1:0] sel;
    logic [7:0] imm, opnd, res;
    logic skip, wback;

    assign op = eio_pkg::eio_op_t'(reg_wdata[`EIO_CMD_OP_LSB+:4]);
    assign sel = reg_wdata[`EIO_CMD_PORT_LSB+:2];
    assign imm = wbyte;

    always_comb begin
        unique case (sel)
            `EIO_PORT_LOW: opnd = low_rd;
            `EIO_PORT_UP: opnd = up_rd;
            default: opnd = dual_rd;
        endcase
        res = opnd;
        skip = 1'b0;
        wback = 1'b0;
        unique case (op)
            eio_pkg::EIO_OP_ADD: begin
                res = opnd + imm;
                wback = 1'b1;
            end
            eio_pkg::EIO_OP_SUB: begin
                res = opnd - imm;
                wback = 1'b1;
            end
            eio_pkg::EIO_OP_AND: begin
                res = opnd & imm;
                wback = 1'b1;
            end
            eio_pkg::EIO_OP_OR: begin
                res = opnd | imm;
                wback = 1'b1;
            end
            eio_pkg::EIO_OP_XOR: begin
                res = opnd ^ imm;
                wback = 1'b1;
            end
            eio_pkg::EIO_OP_GT: skip = opnd > imm;
            eio_pkg::EIO_OP_LT: skip = opnd < imm;
            eio_pkg::EIO_OP_EQ: skip = opnd == imm;
            eio_pkg::EIO_OP_NE: skip = opnd != imm;
            eio_pkg::EIO_OP_ON: skip = (opnd & imm) != 8'h00;
            eio_pkg::EIO_OP_OFF: skip = (opnd & imm) == 8'h00;
            default: skip = 1'b0;
        endcase
    end

    logic [7:0] res_q;
    logic skip_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            res_q <= 8'h00;
            skip_q <= 1'b0;
        end else if (wr_cmd) begin
            res_q <= res;
            skip_q <= skip;
        end
    end

    // ------------------------------------------------------------
    // output latches
    // ------------------------------------------------------------
    logic wb_dual, wb_low, wb_up;

    assign wb_dual = wr_cmd && wback && sel == `EIO_PORT_DUAL;
    assign wb_low = wr_cmd && wback && sel == `EIO_PORT_LOW;
    assign wb_up = wr_cmd && wback && sel == `EIO_PORT_UP;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dual_latch_q <= `EIO_RST_LATCH;
        end else if (wr_dual_latch) begin
            dual_latch_q <= wbyte;
        end else if (wb_dual) begin
            dual_latch_q <= res;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            low_latch_q <= `EIO_RST_LATCH;
        end else if (wr_low_latch) begin
            low_latch_q <= wbyte;
        end else if (wb_low) begin
            low_latch_q <= res;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            up_latch_q <= `EIO_RST_LATCH;
        end else if (wr_up_latch) begin
            up_latch_q <= wbyte;
        end else if (wb_up) begin
            up_latch_q <= res;
        end
    end

    // ------------------------------------------------------------
    // external interrupt request flag
    // ------------------------------------------------------------
    logic irq_set, irq_fall, irq_sel_chg;

    assign irq_fall = dual_fsel_q[`EIO_IRQ_PIN_BIT] && irq_pin_q
                      && !dual_s2_q[`EIO_IRQ_PIN_BIT];
    assign irq_sel_chg = wr_dual_fsel && wbyte[`EIO_IRQ_PIN_BIT]
                         != dual_fsel_q[`EIO_IRQ_PIN_BIT];
    assign irq_set = irq_fall || irq_sel_chg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_irq2_request_flag <= 1'b0;
        end else if (irq_set) begin
            ext_irq2_request_flag <= 1'b1;
        end else if (wr_status && wbyte[0]) begin
            ext_irq2_request_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        unique case (reg_addr)
            `EIO_OFS_DUAL_LATCH: rd_mux = dual_rd;
            `EIO_OFS_DUAL_DIR: rd_mux = dual_dir_q;
            `EIO_OFS_DUAL_FSEL: rd_mux = dual_fsel_q;
            `EIO_OFS_LOW_LATCH: rd_mux = low_rd;
            `EIO_OFS_MEM_MAP: rd_mux = {5'h00, map_q};
            `EIO_OFS_UP_LATCH: rd_mux = up_rd;
            `EIO_OFS_UP_DIR: rd_mux = up_dir_q;
            `EIO_OFS_RMW_RES: rd_mux = res_q;
            `EIO_OFS_STATUS: rd_mux = {5'h00, low_exp, size_bad,
                                       ext_irq2_request_flag};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= {23'h00_0000, wr_cmd ? 1'b0 : skip_q, rd_mux};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_stop_up_dir: assert property (
        hw_stop |=> up_dir_q == 8'hff && up_pin_oe == addr_mask)
        else $error("upper direction not set by stop");
    chk_stop_fsel: assert property (
        hw_stop |=> dual_fsel_q == 8'h00)
        else $error("function select not cleared by stop");
    chk_low_plain_dir: assert property (
        !low_exp |-> low_pin_oe == {8{map_q[0]}})
        else $error("low port pins not switched together");
    chk_low_bus_addr: assert property (
        low_exp && bus_ale |-> low_pin_o == bus_addr[7:0]
                               && low_pin_oe == 8'hff)
        else $error("address not driven with strobe");
    chk_up_addr_full: assert property (
        size == eio_pkg::EIO_SZ_FULL |-> up_pin_o == bus_addr[15:8])
        else $error("upper address not driven");
    chk_cmp_no_wb: assert property (
        wr_cmd && op[3] |=> $stable(dual_latch_q) && $stable(up_latch_q)
                            && $stable(low_latch_q))
        else $error("compare wrote a latch");
    chk_irq_rewrite: assert property (
        irq_sel_chg |=> ext_irq2_request_flag
                        ##1 (ext_irq2_request_flag || $past(wr_status)))
        else $error("select rewrite did not set flag");
    chk_ctrl_read: assert property (
        dual_fsel_q[0] && !dual_dir_q[0] |-> dual_rd[0] == ctrl_out[0])
        else $error("control output read not internal");
    chk_rmw_and: assert property (
        wr_cmd && op == eio_pkg::EIO_OP_AND && sel == 2'h2
        && !wr_up_latch |=> up_latch_q == ($past(up_rd) & $past(imm)))
        else $error("rmw result not written");
    chk_rdata_once: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

endmodule

// ---- test/eio_pin_load.sv ----
// pad load model for one eight-pin port
`timescale 1ns/1ps

module eio_pin_load (
    input wire logic [7:0] drv,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] ext,
    output logic [7:0] pad
);
    // driven pads show the driver, released pads the outside source
    assign pad = (drv & drv_en) | (ext & ~drv_en);
endmodule

// ---- test/expansion_capable_io_ports_tb_top.sv ----
// self-checking bench of the expansion i/o ports
`timescale 1ns/1ps
`include "eio_defs.svh"

module expansion_capable_io_ports_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hw_stop = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] red_rdata;
    logic [7:0] ctrl_in, bus_rdata, red_low_oe, red_up_oe;
    logic irq_flag;
    logic [1:0] size_pins = 2'h0;
    logic [7:0] ctrl_out = 8'h00;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_ale = 1'b0;
    logic bus_we = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] dual_i, dual_o, dual_oe, low_i, low_o, low_oe;
    logic [7:0] up_i, up_o, up_oe;
    logic [7:0] dual_ext = 8'h00;
    logic [7:0] low_ext = 8'h00;
    logic [7:0] up_ext = 8'h00;
    logic [31:0] rng = 32'h4c08_b244;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    eio_pkg::eio_op_t ops [11] = '{eio_pkg::EIO_OP_ADD, eio_pkg::EIO_OP_SUB,
        eio_pkg::EIO_OP_AND, eio_pkg::EIO_OP_OR, eio_pkg::EIO_OP_XOR,
        eio_pkg::EIO_OP_GT, eio_pkg::EIO_OP_EQ, eio_pkg::EIO_OP_NE,
        eio_pkg::EIO_OP_LT, eio_pkg::EIO_OP_ON, eio_pkg::EIO_OP_OFF};

    // ----------------------------------------------------------------
    // design and pad loads
    // ----------------------------------------------------------------
    eio_ports u_eio_ports (.clk_sys(clk_sys), .rst(rst), .hw_stop(hw_stop),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_out(ctrl_out),
        .ctrl_in(ctrl_in), .bus_addr(bus_addr), .bus_ale(bus_ale),
        .bus_we(bus_we), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .dual_pin_i(dual_i), .dual_pin_o(dual_o), .dual_pin_oe(dual_oe),
        .low_pin_i(low_i), .low_pin_o(low_o), .low_pin_oe(low_oe),
        .up_pin_i(up_i), .up_pin_o(up_o), .up_pin_oe(up_oe),
        .size_select_pin_a(1'b0), .size_select_pin_b(1'b0),
        .ext_irq2_request_flag(irq_flag));
    // reduced variant: size pins fix the upper address pins
    eio_ports #(.REDUCED(1'b1)) u_eio_ports_red (.clk_sys(clk_sys),
        .rst(rst), .hw_stop(hw_stop), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(red_rdata), .ctrl_out(ctrl_out), .ctrl_in(),
        .bus_addr(bus_addr), .bus_ale(bus_ale), .bus_we(bus_we),
        .bus_wdata(bus_wdata), .bus_rdata(), .dual_pin_i(8'h00),
        .dual_pin_o(), .dual_pin_oe(), .low_pin_i(8'h00), .low_pin_o(),
        .low_pin_oe(red_low_oe), .up_pin_i(8'h00), .up_pin_o(),
        .up_pin_oe(red_up_oe), .size_select_pin_a(size_pins[0]),
        .size_select_pin_b(size_pins[1]), .ext_irq2_request_flag());
    eio_pin_load u_dual_load (.drv(dual_o), .drv_en(dual_oe),
        .ext(dual_ext), .pad(dual_i));
    eio_pin_load u_low_load (.drv(low_o), .drv_en(low_oe),
        .ext(low_ext), .pad(low_i));
    eio_pin_load u_up_load (.drv(up_o), .drv_en(up_oe),
        .ext(up_ext), .pad(up_i));

    // ----------------------------------------------------------------
    // clock, timeout, helpers
    // ----------------------------------------------------------------
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // skip flag in bit 8, result byte below
    function automatic logic [8:0] rmw_exp(eio_pkg::eio_op_t op,
        logic [7:0] a, logic [7:0] b);
        case (op)
            eio_pkg::EIO_OP_ADD: return {1'b0, a + b};
            eio_pkg::EIO_OP_SUB: return {1'b0, a - b};
            eio_pkg::EIO_OP_AND: return {1'b0, a & b};
            eio_pkg::EIO_OP_OR: return {1'b0, a | b};
            eio_pkg::EIO_OP_XOR: return {1'b0, a ^ b};
            eio_pkg::EIO_OP_GT: return {a > b, 8'h00};
            eio_pkg::EIO_OP_LT: return {a < b, 8'h00};
            eio_pkg::EIO_OP_EQ: return {a == b, 8'h00};
            eio_pkg::EIO_OP_NE: return {a != b, 8'h00};
            eio_pkg::EIO_OP_ON: return {(a & b) != 8'h00, 8'h00};
            default: return {(a & b) == 8'h00, 8'h00};
        endcase
    endfunction

    function automatic logic [7:0] mask_of(logic [1:0] s);
        return (s == 2'h0) ? 8'h00 : (s == 2'h1) ? 8'h0f :
            (s == 2'h2) ? 8'h3f : 8'hff;
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic wr_cmd(input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= `EIO_OFS_RMW_CMD;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v, r;
        logic [8:0] x;
        logic [7:0] rv, imm, m;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk_byte(up_oe, 8'h00);
        chk_byte(low_oe, 8'h00);
        rd(`EIO_OFS_UP_DIR, r);
        chk_byte(r[7:0], 8'hff);
        rd(`EIO_OFS_DUAL_FSEL, r);
        chk_byte(r[7:0], 8'h00);
        rd(6'h3c, r);
        chk_byte(r[7:0], 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = xs();
            up_ext <= v[23:16];
            wr(`EIO_OFS_UP_DIR, v[7:0]);
            wr(`EIO_OFS_UP_LATCH, v[15:8]);
            repeat (3) @(posedge clk_sys);
            rd(`EIO_OFS_UP_LATCH, r);
            rv = (v[15:8] & ~v[7:0]) | (v[23:16] & v[7:0]);
            chk_byte(r[7:0], rv);
            chk_byte(up_oe, ~v[7:0]);
        end
        @(posedge clk_sys);
        hw_stop <= 1'b1;
        @(posedge clk_sys);
        hw_stop <= 1'b0;
        rd(`EIO_OFS_UP_DIR, r);
        chk_byte(r[7:0], 8'hff);
        foreach (ops[k]) begin
            v = xs();
            up_ext <= v[23:16];
            wr(`EIO_OFS_UP_DIR, v[7:0]);
            wr(`EIO_OFS_UP_LATCH, v[15:8]);
            repeat (3) @(posedge clk_sys);
            rv = (v[15:8] & ~v[7:0]) | (v[23:16] & v[7:0]);
            imm = (k % 3 == 0) ? rv : v[31:24];
            wr_cmd({18'h0, `EIO_PORT_UP, ops[k], imm});
            x = rmw_exp(ops[k], rv, imm);
            rd(`EIO_OFS_RMW_RES, r);
            if (ops[k] < eio_pkg::EIO_OP_GT) begin
                chk_byte(r[7:0], x[7:0]);
                chk_byte(up_o, x[7:0]);
            end else begin
                chk_bit(r[8], x[8]);
                chk_byte(up_o, v[15:8]);
            end
        end
        v = xs();
        wr(`EIO_OFS_MEM_MAP, 8'h01);
        wr(`EIO_OFS_LOW_LATCH, v[7:0]);
        #1;
        chk_byte(low_oe, 8'hff);
        chk_byte(low_o, v[7:0]);
        wr_cmd({18'h0, `EIO_PORT_LOW, eio_pkg::EIO_OP_OR, v[31:24]});
        #1;
        chk_byte(low_o, v[7:0] | v[31:24]);
        wr(`EIO_OFS_MEM_MAP, 8'h00);
        low_ext <= v[23:16];
        wr(`EIO_OFS_LOW_LATCH, v[15:8]);
        repeat (3) @(posedge clk_sys);
        chk_byte(low_oe, 8'h00);
        chk_byte(bus_rdata, v[23:16]);
        rd(`EIO_OFS_LOW_LATCH, r);
        chk_byte(r[7:0], v[23:16]);
        wr(`EIO_OFS_MEM_MAP, 8'h01);
        #1;
        chk_byte(low_o, v[15:8]);
        wr(`EIO_OFS_UP_DIR, 8'h55);
        for (int s = 1; s < 4; s++) begin
            m = mask_of(s[1:0]);
            wr(`EIO_OFS_MEM_MAP, {5'h0, s[1:0], 1'b0});
            repeat (4) begin
                v = xs();
                @(posedge clk_sys);
                bus_addr <= v[15:0];
                bus_wdata <= v[23:16];
                bus_ale <= v[24];
                bus_we <= v[25];
                #1;
                chk_byte(low_oe, {8{v[24] | v[25]}});
                chk_byte(low_o, v[24] ? v[7:0] : v[23:16]);
                chk_byte(up_oe, m | (8'haa & ~m));
                chk_byte(up_o & m, v[15:8] & m);
            end
        end
        v = xs();
        ctrl_out <= v[7:0];
        dual_ext <= v[15:8];
        wr(`EIO_OFS_DUAL_LATCH, 8'hff);
        wr(`EIO_OFS_DUAL_FSEL, 8'hff);
        rd(`EIO_OFS_STATUS, r);
        chk_bit(r[0], 1'b1);
        chk_bit(irq_flag, 1'b1);
        wr(`EIO_OFS_STATUS, 8'h01);
        rd(`EIO_OFS_STATUS, r);
        chk_bit(r[0], 1'b0);
        for (int j = 0; j < 2; j++) begin
            wr(`EIO_OFS_DUAL_DIR, {8{j[0]}});
            repeat (3) @(posedge clk_sys);
            rd(`EIO_OFS_DUAL_LATCH, r);
            rv = (v[7:0] & 8'hd1) | (v[15:8] & 8'h2e);
            chk_byte(r[7:0], rv);
            chk_byte(ctrl_in, v[15:8] & 8'h2e);
            chk_byte(dual_oe, 8'hd1);
            chk_byte(dual_o & 8'hd1, v[7:0] & 8'hd1);
        end
        wr_cmd({18'h0, `EIO_PORT_DUAL, eio_pkg::EIO_OP_EQ, rv});
        rd(`EIO_OFS_RMW_RES, r);
        chk_bit(r[8], 1'b1);
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_sys);
            size_pins <= p[1:0];
            bus_ale <= p[0];
            bus_we <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rd(`EIO_OFS_STATUS, r);
            m = (p == 0) ? 8'h0f : (p == 1) ? 8'h3f : (p == 3) ? 8'hff : 8'h00;
            chk_byte(red_up_oe, m | (8'haa & ~m));
            chk_bit(red_rdata[1], p == 2);
            chk_bit(red_rdata[2], 1'b1);
            chk_byte(red_low_oe, {8{p[0]}});
        end
        complete_run();
    end
endmodule
